// *** opc_controller.sv ***
// overfill permissive controller core
`timescale 1ns/100ps
`include "opc_defs.svh"
module opc_controller #(
  parameter int CH       = `OPC_MAX_CH,
  parameter int POLL_CYC = (`OPC_CLK_HZ / 1000000) * `OPC_POLL_US
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // interface sensing, from pin comparators
  input  wire logic          plug_present,
  input  wire logic          five_wire_detect,
  input  wire logic [CH-1:0] ch_dry,
  input  wire logic [CH-1:0] ch_wiring_fault,
  input  wire logic          bond_ok,
  input  wire logic          echo_ok,
  // interrogation drive
  output logic               drive_two_wire,
  output logic               drive_five_wire,
  output logic               poll_strobe,
  // gantry output
  output logic               permit_contact,
  // status lamps
  output opc_pkg::opc_lamps_t lamps,
  output logic [CH-1:0]      wet_lamp
);
  localparam int RESP_CYC = (`OPC_CLK_HZ / 1000) * `OPC_OUT_RESP_MS;
  localparam int WD_W     = $clog2(POLL_CYC * `OPC_WDOG_POLLS + 1);
  localparam int PC_W     = $clog2(POLL_CYC + 1);

  function automatic logic [CH-1:0] opc_mask(input opc_pkg::opc_mode_t m);
    logic [CH-1:0] r;
    r = '0;
    for (int i = 0; i < CH; i++) begin
      if (m == opc_pkg::OPC_MODE_TWO && i < `OPC_TWO_WIRE_CH) begin
        r[i] = 1'b1;
      end else if (m == opc_pkg::OPC_MODE_FIVE && i < `OPC_FIVE_WIRE_CH) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic rs1_reg, rs2_reg, rst_sync_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_reg <= 1'b0;
      rs2_reg <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rs2_reg <= rs1_reg;
    end
  end
  assign rst_sync_n = rs2_reg;

  localparam int SW = 2 * CH + 4;
  logic [SW-1:0] sync_out;
  logic [CH-1:0] dry_s, wfault_s;
  logic          plug_s, five_s, bond_s, echo_s;

  opc_sync3 #(.W(SW)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_sync_n),
    .d_in    ({ch_dry, ch_wiring_fault, plug_present, five_wire_detect, bond_ok, echo_ok}),
    .d_out   (sync_out)
  );
  assign {dry_s, wfault_s, plug_s, five_s, bond_s, echo_s} = sync_out;

  ////////////////////////////////////////////////////////////////////////////
  // self-check poll tick and watchdog
  logic [PC_W-1:0] poll_cnt_reg, poll_cnt_next;
  logic [WD_W-1:0] wd_cnt_reg, wd_cnt_next;
  logic            poll_tick, wd_expired;

  assign poll_tick  = (poll_cnt_reg == PC_W'(POLL_CYC - 1));
  assign wd_expired = (wd_cnt_reg >= WD_W'(POLL_CYC * `OPC_WDOG_POLLS));

  // a missing echo within a few polls is a malfunction
  always_comb begin
    poll_cnt_next = poll_tick ? '0 : poll_cnt_reg + PC_W'(1);
    if (echo_s) begin
      wd_cnt_next = '0;
    end else if (!wd_expired) begin
      wd_cnt_next = wd_cnt_reg + WD_W'(1);
    end else begin
      wd_cnt_next = wd_cnt_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      poll_cnt_reg <= '0;
      wd_cnt_reg   <= '0;
    end else begin
      poll_cnt_reg <= poll_cnt_next;
      wd_cnt_reg   <= wd_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode detection and permit state machine
  opc_pkg::opc_state_t state_reg, state_next;
  opc_pkg::opc_mode_t  mode_reg, mode_next;
  logic [CH-1:0]       mask;
  logic                all_dry, healthy, good;

  assign mask    = opc_mask(mode_reg);
  assign all_dry = ((dry_s & mask) == mask) && (mask != '0);
  assign healthy = ((wfault_s & mask) == '0) && !wd_expired;
  assign good    = plug_s && bond_s && all_dry && healthy;

  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    case (state_reg)
      opc_pkg::OPC_ST_IDLE: begin
        mode_next = opc_pkg::OPC_MODE_NONE;
        if (plug_s) begin
          state_next = opc_pkg::OPC_ST_DETECT;
        end
      end
      opc_pkg::OPC_ST_DETECT: begin
        // mode latched once per connection so the drive stays stable
        mode_next  = five_s ? opc_pkg::OPC_MODE_FIVE : opc_pkg::OPC_MODE_TWO;
        state_next = opc_pkg::OPC_ST_CHECK;
      end
      opc_pkg::OPC_ST_CHECK: begin
        if (!plug_s) begin
          state_next = opc_pkg::OPC_ST_IDLE;
        end else if (good && poll_tick) begin
          state_next = opc_pkg::OPC_ST_PERMIT;
        end
      end
      opc_pkg::OPC_ST_PERMIT: begin
        // drop on the first bad sample, well inside the response limits
        if (!plug_s) begin
          state_next = opc_pkg::OPC_ST_IDLE;
        end else if (!good) begin
          state_next = opc_pkg::OPC_ST_CHECK;
        end
      end
      default: begin
        state_next = opc_pkg::OPC_ST_IDLE;
        mode_next  = opc_pkg::OPC_MODE_NONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= opc_pkg::OPC_ST_IDLE;
      mode_reg  <= opc_pkg::OPC_MODE_NONE;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  logic                permit_reg, permit_next;
  opc_pkg::opc_lamps_t lamps_reg, lamps_next;
  logic [CH-1:0]       wet_reg, wet_next;
  logic                d2_reg, d2_next, d5_reg, d5_next, strobe_reg, strobe_next;

  // contact closes only in the permit state; unpowered relay stays open
  always_comb begin
    permit_next       = (state_next == opc_pkg::OPC_ST_PERMIT);
    lamps_next.red    = !permit_next;
    lamps_next.green  = permit_next;
    lamps_next.bond   = plug_s && bond_s;
    lamps_next.fault  = plug_s && !healthy;
    wet_next          = ~dry_s & mask;
    d2_next           = (mode_next == opc_pkg::OPC_MODE_TWO);
    d5_next           = (mode_next == opc_pkg::OPC_MODE_FIVE);
    strobe_next       = poll_tick && (mode_next != opc_pkg::OPC_MODE_NONE);
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      permit_reg <= 1'b0;
      lamps_reg  <= '{red: 1'b1, green: 1'b0, bond: 1'b0, fault: 1'b0};
      wet_reg    <= '0;
      d2_reg     <= 1'b0;
      d5_reg     <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      permit_reg <= permit_next;
      lamps_reg  <= lamps_next;
      wet_reg    <= wet_next;
      d2_reg     <= d2_next;
      d5_reg     <= d5_next;
      strobe_reg <= strobe_next;
    end
  end

  assign permit_contact  = permit_reg;
  assign lamps           = lamps_reg;
  assign wet_lamp        = wet_reg;
  assign drive_two_wire  = d2_reg;
  assign drive_five_wire = d5_reg;
  assign poll_strobe     = strobe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  int unsigned resp_cnt;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      resp_cnt <= 0;
    end else if (permit_reg && !good) begin
      resp_cnt <= resp_cnt + 1;
    end else begin
      resp_cnt <= 0;
    end
  end

  a_lamps_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    lamps.red == !permit_contact) else $error("red lamp does not mirror non-permissive");
  a_green_permit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    lamps.green == permit_contact) else $error("green lamp does not mirror permissive");
  a_permit_needs_good: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    $rose(permit_contact) |-> $past(good)) else $error("permit granted without good inputs");
  a_bad_drops_permit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (permit_contact && !good) |-> ##1 !permit_contact) else $error("permit held after bad input");
  a_response_bound: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    resp_cnt < RESP_CYC) else $error("response time exceeded");
  a_bond_drop: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (permit_contact && !bond_s) |=> !permit_contact) else $error("permit held without bond");
  a_wiring_fault: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    ((wfault_s & mask) != '0) |=> !permit_contact) else $error("permit during wiring fault");
  a_two_wire_eight: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (mode_reg == opc_pkg::OPC_MODE_TWO && (dry_s[7:0] != 8'hff)) |=> !permit_contact)
    else $error("two-wire wet channel ignored");
  a_drive_mode: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !(drive_two_wire && drive_five_wire)) else $error("both drive modes active");
  a_watchdog_stop: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    wd_expired |=> !permit_contact) else $error("permit with self-check lost");

  c_permit_two: cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
    permit_contact && drive_two_wire);
  c_permit_five: cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
    permit_contact && drive_five_wire);
  c_wet_trip: cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
    permit_contact ##1 !permit_contact && (wet_lamp != '0));
endmodule // opc_controller

// *** opc_defs.svh ***
// timing and sizing constants of the overfill permissive controller
`ifndef OPC_DEFS_SVH
`define OPC_DEFS_SVH
`define OPC_CLK_HZ          100000000
`define OPC_OUT_RESP_MS     450
`define OPC_SYS_RESP_MS     700
`define OPC_SENSOR_RESP_MS  250
`define OPC_TWO_WIRE_CH     8
`define OPC_FIVE_WIRE_CH    12
`define OPC_MAX_CH          12
`define OPC_POLL_US         1000
`define OPC_WDOG_POLLS      4
`endif

// *** opc_pkg.sv ***
// types of the overfill permissive controller
package opc_pkg;
  typedef enum logic [3:0] {
    OPC_ST_IDLE   = 4'b0001,
    OPC_ST_DETECT = 4'b0010,
    OPC_ST_CHECK  = 4'b0100,
    OPC_ST_PERMIT = 4'b1000
  } opc_state_t;

  typedef enum logic [1:0] {
    OPC_MODE_NONE = 2'h0,
    OPC_MODE_TWO  = 2'h1,
    OPC_MODE_FIVE = 2'h2
  } opc_mode_t;

  typedef struct packed {
    logic red;
    logic green;
    logic bond;
    logic fault;
  } opc_lamps_t;
endpackage

// *** opc_sync3.sv ***
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/100ps
`include "opc_defs.svh"
module opc_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [W-1:0] out_next;

  // a bit updates only when stages two and three agree
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= d_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign d_out = out_reg;
endmodule // opc_sync3

// *** opc_vehicle_model.sv ***
// vehicle-side model: compartment sensors, earth bond and self-check echo
`timescale 1ns/100ps
module opc_vehicle_model (
  // clock
  input  wire logic        sys_clk,
  // scenario controls
  input  wire logic        plug,
  input  wire logic        five,
  input  wire logic [11:0] wet,
  input  wire logic [11:0] fault,
  input  wire logic        bond,
  input  wire logic        echo_en,
  input  wire logic        poll_strobe,
  // interface pins
  output logic             plug_present,
  output logic             five_wire_detect,
  output logic [11:0]      ch_dry = 12'h000,
  output logic [11:0]      ch_wiring_fault,
  output logic             bond_ok,
  output logic             echo_ok = 1'b0
);
  logic [1:0] echo_hold = 2'h0;
  ////////////////////////////////////////////////////////////////
  // unplugged socket reads as wet, never as a stale dry level
  // echo held a few cycles: a one-cycle pulse never passes the input agreement filter
  always @(posedge sys_clk) begin
    ch_dry    <= plug ? ~wet : 12'h000;
    echo_hold <= poll_strobe ? 2'h3 : echo_hold - ((echo_hold != 2'h0) ? 2'h1 : 2'h0);
    echo_ok   <= echo_en & (poll_strobe | (echo_hold != 2'h0));
  end
  assign plug_present     = plug;
  assign five_wire_detect = plug & five;
  assign ch_wiring_fault  = fault;
  assign bond_ok          = plug & bond;
endmodule // opc_vehicle_model

// *** opc_controller_tb.sv ***
// self-checking testbench of the overfill permissive controller
`timescale 1ns/100ps
module opc_controller_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, plug = 1'b0, five = 1'b0, bond = 1'b0, echo_en = 1'b1;
  logic [11:0] wet = 12'h000, fault = 12'h000;
  logic plug_present, five_wire_detect, bond_ok, echo_ok;
  logic drive_two_wire, drive_five_wire, poll_strobe, permit_contact;
  logic [11:0] ch_dry, ch_wiring_fault, wet_lamp;
  opc_pkg::opc_lamps_t lamps;
  int failures = 0, checks_done = 0;

  opc_controller #(.CH(12), .POLL_CYC(16)) opc_controller_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .plug_present(plug_present), .five_wire_detect(five_wire_detect),
    .ch_dry(ch_dry), .ch_wiring_fault(ch_wiring_fault), .bond_ok(bond_ok), .echo_ok(echo_ok),
    .drive_two_wire(drive_two_wire), .drive_five_wire(drive_five_wire), .poll_strobe(poll_strobe),
    .permit_contact(permit_contact), .lamps(lamps), .wet_lamp(wet_lamp));
  opc_vehicle_model opc_vehicle_model_i (
    .sys_clk(sys_clk), .plug(plug), .five(five), .wet(wet), .fault(fault), .bond(bond), .echo_en(echo_en),
    .poll_strobe(poll_strobe), .plug_present(plug_present), .five_wire_detect(five_wire_detect),
    .ch_dry(ch_dry), .ch_wiring_fault(ch_wiring_fault), .bond_ok(bond_ok), .echo_ok(echo_ok));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wrap_up;
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // sampled on the falling edge so the rising-edge updates have landed
  task automatic wait_permit(logic exp, int n);
    int i;
    for (i = 0; i < n && permit_contact !== exp; i++) @(negedge sys_clk);
    if (permit_contact !== exp) begin
      check("permit_wait", {11'h000, permit_contact}, {11'h000, exp});
      wrap_up();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    @(negedge sys_clk);
    check("permit_rst", {11'h000, permit_contact}, 12'h000);
    check("lamps_rst", {8'h00, lamps}, 12'h008);
    check("wet_lamp_rst", wet_lamp, 12'h000);
  endtask
  task t_five;
    int n;
    @(posedge sys_clk);
    plug <= 1'b1; five <= 1'b1; bond <= 1'b1;
    wait_permit(1'b1, 200);
    check("lamps_ok", {8'h00, lamps}, 12'h006);
    check("drive5", {10'h000, drive_five_wire, drive_two_wire}, 12'h002);
    // one self-check strobe per poll period of 16 cycles
    n = 0;
    repeat (32) begin
      @(negedge sys_clk);
      if (poll_strobe === 1'b1) n++;
    end
    check("strobes", n[11:0], 12'h002);
    @(posedge sys_clk);
    wet <= 12'h800;
    wait_permit(1'b0, 20);
    check("wet_lamp5", wet_lamp, 12'h800);
    check("red_wet", {10'h000, lamps.red, lamps.green}, 12'h002);
    @(posedge sys_clk);
    wet <= 12'h000;
    wait_permit(1'b1, 200);
  endtask
  task t_two;
    @(posedge sys_clk);
    plug <= 1'b0;
    wait_permit(1'b0, 20);
    repeat (10) @(posedge sys_clk);
    five <= 1'b0; plug <= 1'b1; wet <= 12'h200;
    wait_permit(1'b1, 200);
    check("drive2", {10'h000, drive_five_wire, drive_two_wire}, 12'h001);
    @(posedge sys_clk);
    wet <= 12'h281;
    wait_permit(1'b0, 20);
    check("wet_lamp2", wet_lamp, 12'h081);
    @(posedge sys_clk);
    wet <= 12'h000;
    wait_permit(1'b1, 200);
  endtask
  task t_faults;
    @(posedge sys_clk);
    bond <= 1'b0;
    wait_permit(1'b0, 20);
    check("bond_lamp", {11'h000, lamps.bond}, 12'h000);
    @(posedge sys_clk);
    bond <= 1'b1; fault <= 12'h008;
    repeat (40) @(negedge sys_clk);
    check("permit_wiring", {11'h000, permit_contact}, 12'h000);
    check("fault_lamp", {11'h000, lamps.fault}, 12'h001);
    @(posedge sys_clk);
    fault <= 12'h000;
    wait_permit(1'b1, 200);
    @(posedge sys_clk);
    echo_en <= 1'b0;
    wait_permit(1'b0, 100);
    @(posedge sys_clk);
    echo_en <= 1'b1;
    wait_permit(1'b1, 300);
  endtask
  task t_power_loss;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(negedge sys_clk);
    check("permit_pwr", {11'h000, permit_contact}, 12'h000);
    check("lamps_pwr", {8'h00, lamps}, 12'h008);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_permit(1'b1, 300);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    t_reset();
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_five();
    t_two();
    t_faults();
    t_power_loss();
    wrap_up();
  end
endmodule // opc_controller_tb
